// ---- adrs_status.sv ----
// Data-ready and overwrite status register for a three-axis accelerometer.
`timescale 1ns/1ps
// Summary of operation
// - Mode zero shows axis status at 0x00.
// - Bits: combined ow, Z,Y,X ow, combined dr, Z,Y,X dr.
// - Combined overwrite set on any axis overwrite.
// - Combined overwrite clears after all high bytes read.
// - Z overwrite set on overrun, cleared by read.
// - Y overwrite set on overrun, cleared by read.
// - X overwrite set on overrun, cleared by read.
// - Combined new data set, cleared by high-byte reads.
// - Z new data set on acquisition, cleared by read.
// - Y new data set on acquisition, cleared by read.
// - X new data set on acquisition, cleared by read.
// - Nonzero mode shows queue status instead.
module adrs_status
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [1:0]       queue_mode,
  input  wire adrs_pkg::adrs_axes_t acq_done,
  input  wire adrs_pkg::adrs_axes_t axis_enable,
  input  wire adrs_pkg::adrs_axes_t msb_read,
  input  wire logic [7:0]       queue_status,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  output logic      [7:0]       reg_rdata,
  output logic      [7:0]       axis_data_ready_status
);
  import adrs_pkg::*;

  adrs_axis_if ax ();
  adrs_axes_t  dr;
  adrs_axes_t  ow;
  adrs_axes_t  pend_r;
  adrs_axes_t  pend_nxt;
  logic        cdr_r;
  logic        cdr_nxt;
  logic        cow_r;
  logic        cow_nxt;
  logic        any_ow_evt;
  logic        any_acq;
  logic        all_read;
  logic [7:0]  stat_w;
  logic [7:0]  rsel_w;
  logic [7:0]  rdata_r;
  logic [7:0]  stat_r;
  logic        stat_hit;
  logic        view_axes;

  // ---------------------------------------------------------------
  // Per-axis flags.
  // ---------------------------------------------------------------
  assign ax.acq_done = acq_done & axis_enable;
  assign ax.msb_read = msb_read;
  assign dr = ax.dr_flag;
  assign ow = ax.ow_flag;

  adrs_axis_flags u_flags (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ax       (ax)
  );

  // ---------------------------------------------------------------
  // Combined flags.
  // ---------------------------------------------------------------
  // The combined flags clear only once every high byte has been read since
  // the last acquisition on any axis; pend_r tracks which reads are still owed.
  assign any_acq = |ax.acq_done;
  assign any_ow_evt = |(ax.acq_done & dr & ~msb_read);
  assign all_read = ~|(pend_r & ~msb_read);
  assign pend_nxt = any_acq ? {AXES{1'b1}} : (pend_r & ~msb_read);
  assign cdr_nxt = any_acq | (cdr_r & ~all_read);
  assign cow_nxt = any_ow_evt | (cow_r & ~all_read);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pend_r <= '0;
      cdr_r  <= 1'b0;
      cow_r  <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      cdr_r  <= cdr_nxt;
      cow_r  <= cow_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Register view and read port.
  // ---------------------------------------------------------------
  // A read hits the status byte only at its own address.
  assign stat_hit = reg_rd && (reg_addr == ADRS_STATUS_ADDR);
  assign view_axes = (queue_mode == ADRS_QMODE_OFF);
  assign stat_w = {cow_r, ow, cdr_r, dr};
  assign rsel_w = view_axes ? stat_w
                            : queue_status;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= ADRS_STATUS_RST;
      stat_r  <= ADRS_STATUS_RST;
    end else begin
      stat_r <= stat_w;
      if (stat_hit)
        rdata_r <= rsel_w;
      else if (reg_rd)
        rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign axis_data_ready_status = stat_r;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // New-data flags: set on acquisition, cleared by the high-byte read.
  AST_XDR_SET: assert property (ax.acq_done[0] |=> dr[0])
    else $error("X new data not set");
  AST_YDR_SET: assert property (ax.acq_done[1] |=> dr[1])
    else $error("Y new data not set");
  AST_XDR_CLR: assert property (
    msb_read[0] && !ax.acq_done[0] |=> !dr[0])
    else $error("X new data not cleared");
  AST_YDR_CLR: assert property (
    msb_read[1] && !ax.acq_done[1] |=> !dr[1])
    else $error("Y new data not cleared");
  AST_ZDR_CLR: assert property (
    msb_read[2] && !ax.acq_done[2] |=> !dr[2])
    else $error("Z new data not cleared");
  AST_ENABLE: assert property (
    acq_done[0] && !axis_enable[0] && !dr[0] |=> !dr[0])
    else $error("Disabled axis raised new data");

  // A read in the cycle of a new sample must not eat the new flag.
  AST_XDR_RACE: assert property (
    ax.acq_done[0] && msb_read[0] |=> dr[0])
    else $error("X set lost to clear");
  AST_YDR_RACE: assert property (
    ax.acq_done[1] && msb_read[1] |=> dr[1])
    else $error("Y set lost to clear");
  AST_ZDR_SET: assert property (
    ax.acq_done[2] && msb_read[2] |=> dr[2])
    else $error("Z set lost to clear");

  // Overwrite flags.
  AST_XOW_SET: assert property (
    ax.acq_done[0] && dr[0] && !msb_read[0] |=> ow[0])
    else $error("X overwrite missed");
  AST_YOW_SET: assert property (
    ax.acq_done[1] && dr[1] && !msb_read[1] |=> ow[1])
    else $error("Y overwrite missed");
  AST_ZOW: assert property (
    ax.acq_done[2] && dr[2] && !msb_read[2] |=> ow[2])
    else $error("Z overwrite missed");
  AST_XOW_CLR: assert property (
    msb_read[0] && !ax.acq_done[0] |=> !ow[0])
    else $error("X overwrite not cleared");
  AST_YOW: assert property (
    msb_read[1] && !ax.acq_done[1] |=> !ow[1])
    else $error("Y overwrite not cleared");
  AST_ZOW_CLR: assert property (
    msb_read[2] && !ax.acq_done[2] |=> !ow[2])
    else $error("Z overwrite not cleared");
  AST_XOW: assert property (
    !ow[0] && !(ax.acq_done[0] && dr[0]) |=> !ow[0])
    else $error("X overwrite spurious");
  AST_OW_RACE: assert property (
    ax.acq_done[1] && msb_read[1] |=> !ow[1])
    else $error("Y overwrite set although the old sample was read");

  // Combined flags wait for all three high-byte reads.
  AST_CDR_SET: assert property (
    any_acq |=> cdr_r)
    else $error("Combined new data not set");
  AST_CDR_HOLD: assert property (
    cdr_r && !all_read |=> cdr_r)
    else $error("Combined new data cleared early");
  AST_CLR: assert property (
    cdr_r && all_read && !any_acq |=> !cdr_r)
    else $error("Combined new data stuck");
  AST_COW: assert property (
    any_ow_evt |=> cow_r ##1 stat_r[ADRS_POS_ZYXOW])
    else $error("Combined overwrite missed");
  AST_COW_NONE: assert property (
    !cow_r && !any_ow_evt |=> !cow_r)
    else $error("Combined overwrite spurious");
  AST_COW_HOLD: assert property (
    cow_r && !all_read |=> cow_r)
    else $error("Combined overwrite cleared early");
  AST_COWCLR: assert property (
    cow_r && all_read && !any_ow_evt |=> !cow_r)
    else $error("Combined overwrite stuck");

  // Read port: status view, queue view and unmapped addresses.
  AST_VIEW: assert property (
    stat_hit && !view_axes |=> reg_rdata == $past(queue_status))
    else $error("Queue view wrong");
  AST_MAP: assert property (
    stat_hit && view_axes |=> reg_rdata[ADRS_POS_ZYXDR] == $past(cdr_r))
    else $error("Status view wrong");
  AST_MAP_OW: assert property (
    stat_hit && view_axes
    |=> reg_rdata[ADRS_POS_ZYXOW] == $past(cow_r)
        && reg_rdata[ADRS_POS_XOW +: AXES] == $past(ow)
        && reg_rdata[ADRS_POS_XDR +: AXES] == $past(dr))
    else $error("Status bit map wrong");
  AST_UNMAP: assert property (
    reg_rd && reg_addr != ADRS_STATUS_ADDR |=> reg_rdata == 8'h00)
    else $error("Unmapped read not zero");
  AST_HOLD: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data moved without a read");

  // Main scenarios.
  COV_ACQ: cover property (ax.acq_done[0] ##1 msb_read[0]);
  COV_OW: cover property (any_ow_evt ##1 cow_r);
  COV_RACE: cover property (ax.acq_done[1] && msb_read[1]);
  COV_QV: cover property (reg_rd && queue_mode != ADRS_QMODE_OFF);
  COV_ALLCLR: cover property (cdr_r ##1 !cdr_r);
endmodule

// ---- adrs_pkg.sv ----
// Package with the register map, field positions and types of the status block.
package adrs_pkg;
  localparam int unsigned AXES = 3;
  localparam logic [7:0] ADRS_STATUS_ADDR = 8'h00;
  localparam logic [7:0] ADRS_STATUS_RST = 8'h00;
  localparam logic [1:0] ADRS_QMODE_OFF = 2'h0;
  localparam int unsigned ADRS_POS_XDR = 0;
  localparam int unsigned ADRS_POS_ZYXDR = 3;
  localparam int unsigned ADRS_POS_XOW = 4;
  localparam int unsigned ADRS_POS_ZYXOW = 7;
  typedef logic [AXES-1:0] adrs_axes_t;
endpackage

// ---- adrs_axis_if.sv ----
// Interface carrying per-axis events and flags between the top and the flag unit.
`timescale 1ns/1ps
interface adrs_axis_if;
  import adrs_pkg::*;
  adrs_axes_t acq_done;
  adrs_axes_t msb_read;
  adrs_axes_t dr_flag;
  adrs_axes_t ow_flag;
  modport ctrl (output acq_done, output msb_read, input dr_flag, input ow_flag);
  modport flags (input acq_done, input msb_read, output dr_flag, output ow_flag);
endinterface

// ---- adrs_axis_flags.sv ----
// Per-axis new-data and overwrite flags.
`timescale 1ns/1ps
module adrs_axis_flags
(
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  adrs_axis_if.flags ax
);
  import adrs_pkg::*;

  adrs_axes_t dr_r;
  adrs_axes_t dr_nxt;
  adrs_axes_t ow_r;
  adrs_axes_t ow_nxt;

  // ---------------------------------------------------------------
  // Flag update, new-data set wins over clear, overwrite clear wins over set.
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      assign dr_nxt[g] = ax.acq_done[g] | (dr_r[g] & ~ax.msb_read[g]);
      // Overwrite when a sample lands while the previous one is unread.
      assign ow_nxt[g] = (ax.acq_done[g] & dr_r[g] & ~ax.msb_read[g])
                       | (ow_r[g] & ~ax.msb_read[g]);
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dr_r <= '0;
      ow_r <= '0;
    end else begin
      dr_r <= dr_nxt;
      ow_r <= ow_nxt;
    end
  end

  assign ax.dr_flag = dr_r;
  assign ax.ow_flag = ow_r;
endmodule

// ---- adrs_host_model.sv ----
// Host model that issues status reads and high-byte output reads.
`timescale 1ns/1ps
module adrs_host_model
(
  input  wire logic           core_clk,
  input  wire logic [7:0]     reg_rdata,
  output logic                reg_rd,
  output adrs_pkg::adrs_axes_t msb_read,
  output logic [7:0]          reg_addr
);
  import adrs_pkg::*;

  initial begin
    reg_rd = 1'b0;
    msb_read = '0;
    reg_addr = 8'h00;
  end
  task automatic hit(input adrs_axes_t m);
    msb_read = m;
  endtask
  // A released address shows its inverse, so a stale value cannot match.
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    reg_rd = 1'b1;
    reg_addr = ad;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~ad;
    @(posedge core_clk);
    #1;
  endtask
endmodule

// ---- adrs_status_tb.sv ----
// Self-checking bench for the axis data-ready status block.
`timescale 1ns/1ps
module adrs_status_tb;
  import adrs_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] queue_mode = 2'h0;
  adrs_axes_t acq_done = '0;
  adrs_axes_t axis_enable = '1;
  adrs_axes_t msb_read, mdr, mow, sk, a, ovr;
  logic [7:0] queue_status = 8'h00;
  logic [7:0] reg_addr, reg_rdata, status, d, ms;
  logic       reg_rd, cdr, cow, done;
  logic [31:0] seed = 32'h0001_03ba;
  logic [31:0] r;
  int         fails = 0;
  int         cmp_count = 0;
  logic [7:0] exp_q[$];
  always #5 core_clk = ~core_clk;
  adrs_status adrs_status_inst (.core_clk, .rst_n, .queue_mode, .acq_done,
    .axis_enable, .msb_read, .queue_status, .reg_rd, .reg_addr,
    .reg_rdata, .axis_data_ready_status(status));
  adrs_host_model adrs_host_model_inst (.core_clk, .reg_rdata, .reg_rd,
    .msb_read, .reg_addr);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] got, want);
    cmp_count++;
    if (got !== want) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic rdchk(input logic [7:0] ad);
    logic [7:0] want;
    want = (ad != ADRS_STATUS_ADDR) ? 8'h00 :
      (queue_mode == ADRS_QMODE_OFF) ? {cow, mow, cdr, mdr} : queue_status;
    exp_q.push_back(want);
    adrs_host_model_inst.rd(ad, d);
    chk(d, exp_q.pop_front());
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    a = acq_done & axis_enable;
    ovr = a & mdr & ~msb_read;
    done = ((sk | msb_read) == 3'b111);
    ms = {cow, mow, cdr, mdr};
    sk = (|a || done) ? 3'b000 : sk | msb_read;
    cow = |ovr || (cow && !done);
    cdr = |a || (cdr && !done);
    mow = ovr | (mow & ~msb_read);
    mdr = a | (mdr & ~msb_read);
    if (!rst_n) {cow, mow, cdr, mdr, sk, ms} = '0;
    #1 chk(status, ms);
  end
  initial begin
    #200_000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 600; i++) begin
      r = xs();
      acq_done = r[2:0] & {3{r[3] & r[4]}};
      axis_enable = r[12:10] | {3{r[13]}};
      adrs_host_model_inst.hit(r[8:6] & {3{r[9]}});
      rst_n = (i != 300);
      @(posedge core_clk);
      #1;
    end
    $display("test random events done");
    axis_enable = '1;
    acq_done = 3'b111;
    adrs_host_model_inst.hit(3'b111);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      #1;
      acq_done = '0;
      adrs_host_model_inst.hit(3'b001 << k);
    end
    acq_done = 3'b111;
    @(posedge core_clk);
    #1;
    acq_done = '0;
    repeat (2) @(posedge core_clk);
    #1;
    $display("test same-cycle set and clear done");
    for (int q = 0; q < 4; q++) begin
      queue_mode = q[1:0];
      queue_status = 8'(xs());
      rdchk(8'h00);
      rdchk(8'h01);
      rdchk(8'hff);
    end
    $display("test register reads done");
    stop_test();
  end
endmodule
